// ### verification/fcs_assertions.sv
// Port checker for the flash command sequencer host.
// Bound into fcs_host; sees only its ports.
`timescale 1ns/1ps
module fcs_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic busy,
  input wire logic erase_suspended,
  input wire logic [7:0] status,
  // Flash pins
  input wire logic [22:0] flash_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic reset_powerdown_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  write_pins_a: assert property (!wr_en_n |-> !chip_en_n && out_en_n && dq_oe)
    else $error("write strobe without enable");
  read_pins_a: assert property (!out_en_n |-> !chip_en_n && !dq_oe && wr_en_n)
    else $error("read strobe with bus conflict");
  erase_start_a: assert property (cmd_valid && cmd_ready && !busy
    && cmd_op == fcs_pkg::OP_ERASE |-> ##[1:300] !wr_en_n)
    else $error("erase issued no write");
  latch_hold_a: assert property ($rose(wr_en_n) |-> $stable(flash_addr) && $stable(dq_out))
    else $error("address or data moved at latch");
  strobe_width_a: assert property ($fell(wr_en_n) |-> !wr_en_n [*8])
    else $error("write strobe too short");
  pin_reset_a: assert property (!reset_powerdown_n |-> chip_en_n && wr_en_n)
    else $error("bus cycle during pin reset");
  busy_refuse_a: assert property (cmd_ready && busy |-> cmd_op == fcs_pkg::OP_SUSPEND)
    else $error("command taken while busy");
  suspend_end_a: assert property (cmd_valid && cmd_ready && busy |-> ##[1:600] !busy)
    else $error("suspend never settled");
  esusp_bits_a: assert property ($rose(erase_suspended)
    |-> status[fcs_pkg::ST_ESUSP] && status[fcs_pkg::ST_READY])
    else $error("suspend flag without status bits");
endmodule
bind fcs_host fcs_assertions u_chk (.*);

// ### verification/fcs_flash_model.sv
// Behavioural flash command interface answering the host's bus cycles.
// Writes latch on write enable rising; a shortened controller timer runs on sys_clk.
`timescale 1ns/1ps
module fcs_flash_model (
  // Timer clock
  input wire logic sys_clk,
  // Flash pins
  input wire logic [22:0] flash_addr,
  output logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic reset_powerdown_n
);
  logic [15:0] mem [16];
  logic [15:0] rd, last;
  logic [63:0] prot = '0;
  logic [7:0] st, pend, n, d;
  logic [1:0] md;
  logic sus, ers, pr;
  int tmr;
  wire rdy = tmr == 0 || sus;
  wire [5:0] blk = flash_addr[22:17];
  wire [3:0] w = flash_addr[4:1];
  initial foreach (mem[i]) mem[i] = 16'h1234;
  task automatic go(input int t, input logic e, input logic p);
    tmr = t;
    ers = e;
    pr = p;
  endtask
  // Timer steps off the host's sampling edge so status never races a read
  always @(negedge sys_clk) if (tmr > 0 && !sus) tmr = tmr - 1;
  always @(posedge wr_en_n or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      md = 0;
      pend = 0;
      st = 0;
      go(0, 0, 0);
      sus = 0;
    end else if (!chip_en_n && dq_oe) begin
      d = dq_out[7:0];
      md = 1;
      if (!rdy) begin
        if (d == 8'hb0 && !pr) sus = 1;
      end else if (pend == 8'h20) begin
        pend = 0;
        if (prot[blk]) st = st | 8'h22;
        else begin
          foreach (mem[i]) mem[i] = '1;
          go(400, 1, 0);
        end
      end else if (pend == 8'h40) begin
        pend = 0;
        if (prot[blk]) st = st | 8'h12;
        else begin
          mem[w] = mem[w] & dq_out;
          go(40, 0, 0);
        end
      end else if (pend == 8'h60) begin
        pend = 0;
        prot[blk] = 1'b1;
        go(40, 0, 1);
      end else if (pend == 8'he8) begin
        pend = 8'h01;
        n = d;
      end else if (pend == 8'h01) begin
        if (!prot[blk]) mem[w] = mem[w] & dq_out;
        if (n == 0) pend = 8'h02;
        n = n - 8'h1;
      end else if (pend == 8'h02) begin
        pend = 0;
        if (d != 8'hd0) st = st | 8'h30;
        else go(40, 0, 0);
      end else case (d)
        8'hff: md = 0;
        8'h98: md = 2;
        8'h90: md = 3;
        8'h50: st = st & 8'hc5;
        8'hd0: sus = 0;
        8'h20, 8'h40, 8'he8, 8'h60: pend = d;
        default: ;
      endcase
    end
  end
  // Status carries suspend flags live so a finished operation shows neither
  assign rd = md == 0 ? mem[w] : md == 2 ? 16'h0051 : md == 3 ? 16'h0000 :
    {8'h00, rdy, sus && ers, st[5:3], sus && !ers, st[1], 1'b0};
  always @(posedge out_en_n) last = rd;
  // A released bus shows the inverse of the last word, never a stale copy
  assign dq_in = (!chip_en_n && !out_en_n && reset_powerdown_n) ? rd : ~last;
endmodule

// ### verification/testbench.sv
// Self-checking bench driving fcs_host commands against the flash model.
// Assumes the model's shortened controller timers; one command at a time.
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rstn, cmd_valid, cmd_ready, ld_valid, ld_ready, cmd_done, cmd_fail;
  logic busy, erase_suspended, program_suspended, dq_oe, chip_en_n, out_en_n, wr_en_n;
  logic reset_powerdown_n;
  logic [3:0] cmd_op, cmd_count;
  logic [22:0] cmd_addr, flash_addr;
  logic [15:0] cmd_data, ld_data, rd_data, dq_in, dq_out;
  logic [7:0] status;
  logic [4:0] ld_addr;
  logic [4:0] li = '0;
  int fails, num_checks;
  fcs_host u_dut (.*);
  fcs_flash_model u_mem (.*);
  assign ld_addr = {li[3:0], 1'b0};
  assign ld_data = 16'h1000 + {11'h0, li};
  always @(posedge sys_clk) if (ld_valid && ld_ready) li <= li + 5'h1;
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [22:0] a, input bit wt = 1);
    int n;
    @(posedge sys_clk);
    #1;
    {cmd_op, cmd_addr, cmd_valid} = {op, a, 1'b1};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    #1 cmd_valid = 0;
    while (wt && cmd_done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) fails++;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    complete_run;
  end
  initial begin
    int n;
    {rstn, cmd_valid, ld_valid, cmd_op, cmd_addr, cmd_data} = '0;
    cmd_count = 4'h3;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1;
    run(4'h0, 23'h4);
    chk(rd_data, 16'h1234);
    run(4'h2, 23'h0);
    chk(rd_data, 16'h0051);
    run(4'h1, 23'h0);
    chk(rd_data, 16'h0000);
    run(4'h3, 23'h0);
    chk(rd_data, 16'h0080);
    run(4'h5, 23'h0);
    chk({15'h0, cmd_fail}, 16'h0);
    run(4'h0, 23'h6);
    chk(rd_data, 16'hffff);
    #1 cmd_data = 16'h00a5;
    run(4'h6, 23'h1e);
    run(4'h0, 23'h1e);
    chk(rd_data, 16'h00a5);
    run(4'ha, 23'h20000);
    chk({15'h0, cmd_fail}, 16'h0);
    run(4'h5, 23'h20000);
    chk({8'h0, status}, 16'h00a2);
    run(4'h6, 23'h20002);
    chk({8'h0, status}, 16'h0092);
    run(4'h4, 23'h0);
    run(4'h3, 23'h0);
    chk(rd_data, 16'h0080);
    #1 ld_valid = 1;
    run(4'h7, 23'h0);
    #1 ld_valid = 0;
    run(4'h0, 23'h2);
    chk(rd_data, 16'h1001);
    run(4'h5, 23'h0, 0);
    repeat (60) @(posedge sys_clk);
    run(4'h8, 23'h0, 0);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({15'h0, erase_suspended}, 16'h1);
    chk({15'h0, program_suspended}, 16'h0);
    run(4'h5, 23'h0);
    chk({15'h0, cmd_fail}, 16'h1);
    run(4'h3, 23'h0);
    chk(rd_data, 16'h00c0);
    run(4'h0, 23'h2);
    chk(rd_data, 16'hffff);
    run(4'h9, 23'h0);
    chk({15'h0, erase_suspended}, 16'h0);
    complete_run;
  end
endmodule

// ### verilog/fcs_bus.sv
// One asynchronous flash bus cycle at a time, plus the hardware reset pulse.
// Assumes dq_in is already synchronous to sys_clk; single chip enable, the others tied active.
`timescale 1ns/1ps
module fcs_bus (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Cycle request from the sequencer
  input wire logic req,
  input wire logic req_write,
  input wire logic [22:0] req_addr,
  input wire logic [15:0] req_data,
  output logic bus_idle,
  output logic ack,
  output logic [15:0] rdata,
  // Flash pins
  output logic [22:0] flash_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic chip_en_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic reset_powerdown_n
);

  typedef struct packed {
    fcs_pkg::fcs_bstate_t st;
    logic [7:0] cnt;
    logic wr;
    logic [22:0] addr;
    logic [15:0] dout;
    logic oe;
    logic ce_n;
    logic g_n;
    logic w_n;
    logic rp_n;
    logic ack;
    logic [15:0] rdata;
  } fcs_bus_t;

  fcs_bus_t s;
  fcs_bus_t next_s;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.cnt = s.cnt + 8'h01;
    case (s.st)
      fcs_pkg::B_RST: begin
        // Reset pin held low long enough; device then comes up in array read mode
        if (s.cnt >= 8'(fcs_pkg::N_RP)) begin
          next_s.st = fcs_pkg::B_RPH;
          next_s.rp_n = 1'b1;
          next_s.cnt = 8'h00;
        end
      end
      fcs_pkg::B_RPH: begin
        if (s.cnt >= 8'(fcs_pkg::N_RPH)) begin
          next_s.st = fcs_pkg::B_IDLE;
        end
      end
      fcs_pkg::B_IDLE: begin
        next_s.cnt = 8'h00;
        if (req) begin
          next_s.st = fcs_pkg::B_SETUP;
          next_s.wr = req_write;
          next_s.addr = req_addr;
          next_s.dout = req_data;
          next_s.oe = req_write;
          next_s.ce_n = 1'b0;
        end
      end
      fcs_pkg::B_SETUP: begin
        if (s.cnt >= 8'(fcs_pkg::N_AS)) begin
          next_s.st = fcs_pkg::B_STROBE;
          next_s.cnt = 8'h00;
          next_s.w_n = ~s.wr;
          next_s.g_n = s.wr;
        end
      end
      fcs_pkg::B_STROBE: begin
        // Data is latched by the device on the rising write enable edge
        if (s.cnt >= 8'(s.wr ? fcs_pkg::N_WP : fcs_pkg::N_ACC)) begin
          next_s.st = fcs_pkg::B_HOLD;
          next_s.cnt = 8'h00;
          next_s.w_n = 1'b1;
          next_s.g_n = 1'b1;
          if (!s.wr) begin
            next_s.rdata = dq_in;
          end
        end
      end
      fcs_pkg::B_HOLD: begin
        if (s.cnt >= 8'(fcs_pkg::N_WH)) begin
          next_s.st = fcs_pkg::B_IDLE;
          next_s.ce_n = 1'b1;
          next_s.oe = 1'b0;
          next_s.ack = 1'b1;
        end
      end
      default: begin
        next_s.st = fcs_pkg::B_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: fcs_pkg::B_RST, ce_n: 1'b1, g_n: 1'b1, w_n: 1'b1, rp_n: 1'b0, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign bus_idle = (s.st == fcs_pkg::B_IDLE);
  assign ack = s.ack;
  assign rdata = s.rdata;
  assign flash_addr = s.addr;
  assign dq_out = s.dout;
  assign dq_oe = s.oe;
  assign chip_en_n = s.ce_n;
  assign out_en_n = s.g_n;
  assign wr_en_n = s.w_n;
  assign reset_powerdown_n = s.rp_n;

endmodule

// ### verilog/fcs_host.sv
// Host-side command sequencer for a parallel NOR flash command interface.
// Assumes one user command at a time and a word-wide device; buffer words come on a load port.
`timescale 1ns/1ps
module fcs_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [22:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic [3:0] cmd_count,
  // Buffered program word loads
  input wire logic ld_valid,
  output logic ld_ready,
  input wire logic [4:0] ld_addr,
  input wire logic [15:0] ld_data,
  // Results
  output logic cmd_done,
  output logic cmd_fail,
  output logic [15:0] rd_data,
  output logic [7:0] status,
  output logic busy,
  output logic erase_suspended,
  output logic program_suspended,
  // Flash pins
  output logic [22:0] flash_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic chip_en_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic reset_powerdown_n
);

  typedef struct packed {
    fcs_pkg::fcs_state_t st;
    fcs_pkg::fcs_op_t op;
    logic [22:0] addr;
    logic [15:0] data;
    logic [3:0] count;
    logic [3:0] idx;
    logic wait_ack;
    logic req;
    logic req_write;
    logic [22:0] req_addr;
    logic [15:0] req_data;
    logic err_pend;
    logic esusp;
    logic psusp;
    logic need_ra;
    logic susp_req;
    logic [5:0] erase_blk;
    logic done;
    logic fail;
    logic [15:0] rdata;
    logic [7:0] status;
  } fcs_host_t;

  fcs_host_t s;
  fcs_host_t next_s;
  logic bus_idle;
  logic bus_ack;
  logic [15:0] bus_rdata;
  logic susp_ok;
  logic suspend_take;
  logic [7:0] opcode;
  logic legal;
  logic is_launch;

  fcs_bus u_bus (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .req(s.req),
    .req_write(s.req_write),
    .req_addr(s.req_addr),
    .req_data(s.req_data),
    .bus_idle(bus_idle),
    .ack(bus_ack),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .chip_en_n(chip_en_n),
    .out_en_n(out_en_n),
    .wr_en_n(wr_en_n),
    .reset_powerdown_n(reset_powerdown_n)
  );

  // Suspend only for a running erase or program; protect cannot be paused
  assign susp_ok = (s.st == fcs_pkg::S_POLL) && !s.susp_req && !s.wait_ack &&
                   (s.op == fcs_pkg::OP_ERASE || s.op == fcs_pkg::OP_PROGRAM ||
                    s.op == fcs_pkg::OP_BUF_PROGRAM);
  assign suspend_take = susp_ok && cmd_valid && (cmd_op == fcs_pkg::OP_SUSPEND);
  assign cmd_ready = (s.st == fcs_pkg::S_IDLE) || suspend_take;
  assign ld_ready = (s.st == fcs_pkg::S_LOAD) && !s.wait_ack && bus_idle;
  assign is_launch = (s.op == fcs_pkg::OP_ERASE) || (s.op == fcs_pkg::OP_PROGRAM) ||
                     (s.op == fcs_pkg::OP_BUF_PROGRAM) || (s.op == fcs_pkg::OP_PROTECT) ||
                     (s.op == fcs_pkg::OP_RESUME);

  // Opcode of the first write of each sequence
  always_comb begin
    case (s.op)
      fcs_pkg::OP_READ_ARRAY: opcode = fcs_pkg::OPC_READ_ARRAY;
      fcs_pkg::OP_READ_SIG: opcode = fcs_pkg::OPC_READ_SIG;
      fcs_pkg::OP_READ_QUERY: opcode = fcs_pkg::OPC_READ_QUERY;
      fcs_pkg::OP_READ_STATUS: opcode = fcs_pkg::OPC_READ_STATUS;
      fcs_pkg::OP_CLEAR: opcode = fcs_pkg::OPC_CLEAR;
      fcs_pkg::OP_ERASE: opcode = fcs_pkg::OPC_ERASE;
      fcs_pkg::OP_PROGRAM: opcode = fcs_pkg::OPC_PROGRAM;
      fcs_pkg::OP_BUF_PROGRAM: opcode = fcs_pkg::OPC_BUF_PROGRAM;
      fcs_pkg::OP_RESUME: opcode = fcs_pkg::OPC_CONFIRM;
      fcs_pkg::OP_PROTECT: opcode = fcs_pkg::OPC_PROTECT;
      default: opcode = fcs_pkg::OPC_READ_STATUS;
    endcase
  end

  // What the device accepts while something is suspended
  always_comb begin
    legal = 1'b1;
    case (fcs_pkg::fcs_op_t'(cmd_op))
      fcs_pkg::OP_ERASE, fcs_pkg::OP_PROTECT: legal = !s.esusp && !s.psusp;
      fcs_pkg::OP_PROGRAM, fcs_pkg::OP_BUF_PROGRAM: begin
        // Programming inside the block being erased would be corrupted
        legal = !s.psusp && !(s.esusp && cmd_addr[22:fcs_pkg::BLOCK_LSB] == s.erase_blk);
      end
      fcs_pkg::OP_RESUME: legal = s.esusp || s.psusp;
      fcs_pkg::OP_SUSPEND: legal = 1'b0;
      default: legal = 1'b1;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.req = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      fcs_pkg::S_IDLE: begin
        if (cmd_valid) begin
          next_s.op = fcs_pkg::fcs_op_t'(cmd_op);
          next_s.addr = cmd_addr;
          next_s.data = cmd_data;
          next_s.count = cmd_count;
          next_s.susp_req = 1'b0;
          if (!legal) begin
            next_s.done = 1'b1;
            next_s.fail = 1'b1;
          end else if (s.err_pend && (cmd_op == fcs_pkg::OP_ERASE ||
                       cmd_op == fcs_pkg::OP_PROGRAM || cmd_op == fcs_pkg::OP_BUF_PROGRAM ||
                       cmd_op == fcs_pkg::OP_PROTECT || cmd_op == fcs_pkg::OP_RESUME)) begin
            next_s.st = fcs_pkg::S_CLEAR;
          end else if (cmd_op == fcs_pkg::OP_RESUME && s.need_ra) begin
            next_s.st = fcs_pkg::S_PRE_RA;
          end else begin
            next_s.st = fcs_pkg::S_CMD;
          end
        end
      end
      fcs_pkg::S_CLEAR, fcs_pkg::S_PRE_RA, fcs_pkg::S_CMD, fcs_pkg::S_ARG,
      fcs_pkg::S_COUNT, fcs_pkg::S_CONFIRM, fcs_pkg::S_SUSP: begin
        if (!s.wait_ack && bus_idle) begin
          next_s.req = 1'b1;
          next_s.wait_ack = 1'b1;
          next_s.req_write = 1'b1;
          next_s.req_addr = s.addr;
          case (s.st)
            fcs_pkg::S_CLEAR: next_s.req_data = {8'h00, fcs_pkg::OPC_CLEAR};
            fcs_pkg::S_PRE_RA: next_s.req_data = {8'h00, fcs_pkg::OPC_READ_ARRAY};
            fcs_pkg::S_CMD: next_s.req_data = {8'h00, opcode};
            fcs_pkg::S_COUNT: next_s.req_data = {12'h000, s.count};
            fcs_pkg::S_CONFIRM: next_s.req_data = {8'h00, fcs_pkg::OPC_CONFIRM};
            fcs_pkg::S_SUSP: next_s.req_data = {8'h00, fcs_pkg::OPC_SUSPEND};
            default: begin
              if (s.op == fcs_pkg::OP_ERASE) begin
                next_s.req_data = {8'h00, fcs_pkg::OPC_CONFIRM};
              end else if (s.op == fcs_pkg::OP_PROTECT) begin
                next_s.req_data = {8'h00, fcs_pkg::OPC_PROTECT_ARG};
              end else begin
                next_s.req_data = s.data;
              end
            end
          endcase
        end
        if (bus_ack) begin
          next_s.wait_ack = 1'b0;
          case (s.st)
            fcs_pkg::S_CLEAR: begin
              next_s.err_pend = 1'b0;
              next_s.st = (s.op == fcs_pkg::OP_RESUME && s.need_ra) ? fcs_pkg::S_PRE_RA
                                                                    : fcs_pkg::S_CMD;
            end
            fcs_pkg::S_PRE_RA: begin
              next_s.need_ra = 1'b0;
              next_s.st = fcs_pkg::S_CMD;
            end
            fcs_pkg::S_CMD: begin
              if (s.op == fcs_pkg::OP_CLEAR) begin
                next_s.err_pend = 1'b0;
                next_s.done = 1'b1;
                next_s.fail = 1'b0;
                next_s.st = fcs_pkg::S_IDLE;
              end else if (s.op == fcs_pkg::OP_RESUME) begin
                next_s.st = fcs_pkg::S_POLL;
              end else if (s.op == fcs_pkg::OP_BUF_PROGRAM) begin
                next_s.st = fcs_pkg::S_COUNT;
              end else if (is_launch) begin
                next_s.st = fcs_pkg::S_ARG;
              end else begin
                next_s.st = fcs_pkg::S_READ;
              end
            end
            fcs_pkg::S_COUNT: begin
              next_s.idx = 4'h0;
              next_s.st = fcs_pkg::S_LOAD;
            end
            fcs_pkg::S_SUSP: begin
              next_s.susp_req = 1'b1;
              next_s.st = fcs_pkg::S_POLL;
            end
            default: begin
              if (s.op == fcs_pkg::OP_ERASE) begin
                next_s.erase_blk = s.addr[22:fcs_pkg::BLOCK_LSB];
              end
              next_s.st = fcs_pkg::S_POLL;
            end
          endcase
        end
      end
      fcs_pkg::S_LOAD: begin
        if (ld_ready && ld_valid) begin
          // Page bits come from the setup address so every load stays in one page
          next_s.req = 1'b1;
          next_s.wait_ack = 1'b1;
          next_s.req_write = 1'b1;
          next_s.req_addr = {s.addr[22:fcs_pkg::PAGE_LSB], ld_addr};
          next_s.req_data = ld_data;
        end
        if (bus_ack) begin
          next_s.wait_ack = 1'b0;
          next_s.idx = s.idx + 4'h1;
          if (s.idx == s.count || s.idx == fcs_pkg::BUF_MAX) begin
            next_s.st = fcs_pkg::S_CONFIRM;
          end
        end
      end
      fcs_pkg::S_POLL, fcs_pkg::S_READ: begin
        if (suspend_take) begin
          next_s.st = fcs_pkg::S_SUSP;
        end else if (!s.wait_ack && bus_idle) begin
          next_s.req = 1'b1;
          next_s.wait_ack = 1'b1;
          next_s.req_write = 1'b0;
          next_s.req_addr = (s.st == fcs_pkg::S_READ) ? s.addr : 23'h000000;
        end
        if (bus_ack) begin
          next_s.wait_ack = 1'b0;
          if (s.st == fcs_pkg::S_READ) begin
            next_s.rdata = bus_rdata;
            if (s.op == fcs_pkg::OP_READ_STATUS) begin
              next_s.status = bus_rdata[7:0];
            end
            next_s.done = 1'b1;
            next_s.fail = 1'b0;
            next_s.st = fcs_pkg::S_IDLE;
          end else if (bus_rdata[fcs_pkg::ST_READY]) begin
            // Controller idle: finished, failed or paused
            next_s.status = bus_rdata[7:0];
            next_s.rdata = bus_rdata;
            next_s.fail = |(bus_rdata[7:0] & fcs_pkg::ST_ERR_MASK);
            next_s.err_pend = s.err_pend | (|(bus_rdata[7:0] & fcs_pkg::ST_ERR_MASK));
            next_s.done = 1'b1;
            next_s.st = fcs_pkg::S_IDLE;
            if (s.op == fcs_pkg::OP_RESUME) begin
              next_s.psusp = s.psusp ? bus_rdata[fcs_pkg::ST_PSUSP] : 1'b0;
              next_s.esusp = (s.esusp && !s.psusp) ? bus_rdata[fcs_pkg::ST_ESUSP] : s.esusp;
            end else if (s.susp_req) begin
              next_s.esusp = s.esusp | bus_rdata[fcs_pkg::ST_ESUSP];
              next_s.psusp = bus_rdata[fcs_pkg::ST_PSUSP];
            end
            if (s.esusp && (s.op == fcs_pkg::OP_PROGRAM || s.op == fcs_pkg::OP_BUF_PROGRAM ||
                            (s.op == fcs_pkg::OP_RESUME && s.psusp)) &&
                !bus_rdata[fcs_pkg::ST_PSUSP]) begin
              next_s.need_ra = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.st = fcs_pkg::S_IDLE;
      end
    endcase
  end

  // Device powers up in array read mode, so no mode state needs restoring here
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: fcs_pkg::S_IDLE, op: fcs_pkg::OP_READ_ARRAY, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign cmd_done = s.done;
  assign cmd_fail = s.fail;
  assign rd_data = s.rdata;
  assign status = s.status;
  assign busy = (s.st != fcs_pkg::S_IDLE);
  assign erase_suspended = s.esusp;
  assign program_suspended = s.psusp;

endmodule

// ### verilog/fcs_pkg.sv
// Constants, timing counts and types shared by the flash command sequencer host.
// Assumes a 125 MHz sys_clk and a word-wide flash with the status byte on the low data lines.
// Functional notes
// - Host issues clear-status after any error before program, erase or resume.
// - Erase is two writes; second latches block, starts controller, reads give status.
// - Single program is setup write then address/data write that starts the controller.
// - Write buffer holds 16 words; all loads share A5-A22.
// - Buffer program: setup at block, count N, N+1 loads, then confirm write.
// - After suspend poll bit 7; other commands rejected until the controller paused.
// - Program done inside erase suspend needs array read before resume; avoid erasing block.
package fcs_pkg;

  // Clock and bus timing; the ns figures are plain defaults for a typical part
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned T_AS_NS = 10;
  localparam int unsigned T_WP_NS = 70;
  localparam int unsigned T_WH_NS = 30;
  localparam int unsigned T_ACC_NS = 110;
  localparam int unsigned T_RP_NS = 100;
  localparam int unsigned T_RPH_NS = 150;
  localparam int unsigned N_AS = (T_AS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned N_WP = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned N_WH = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned N_ACC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned N_RP = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned N_RPH = (T_RPH_NS * CLK_MHZ + 999) / 1000;

  // Opcodes written on the first cycle of each sequence, and the protect argument written on the second
  localparam logic [7:0] OPC_READ_ARRAY = 8'hff;
  localparam logic [7:0] OPC_READ_SIG = 8'h90;
  localparam logic [7:0] OPC_READ_STATUS = 8'h70;
  localparam logic [7:0] OPC_READ_QUERY = 8'h98;
  localparam logic [7:0] OPC_CLEAR = 8'h50;
  localparam logic [7:0] OPC_ERASE = 8'h20;
  localparam logic [7:0] OPC_PROGRAM = 8'h40;
  localparam logic [7:0] OPC_BUF_PROGRAM = 8'he8;
  localparam logic [7:0] OPC_SUSPEND = 8'hb0;
  localparam logic [7:0] OPC_CONFIRM = 8'hd0;
  localparam logic [7:0] OPC_PROTECT = 8'h60;
  localparam logic [7:0] OPC_PROTECT_ARG = 8'h01;

  // Status byte layout
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_ESUSP = 6;
  localparam int unsigned ST_PSUSP = 2;
  localparam logic [7:0] ST_ERR_MASK = 8'h3a;

  // Address fields of a byte address: buffer page and 128 KB block
  localparam int unsigned PAGE_LSB = 5;
  localparam int unsigned BLOCK_LSB = 17;
  localparam logic [3:0] BUF_MAX = 4'hf;

  typedef enum logic [3:0] {
    OP_READ_ARRAY = 4'b0000,
    OP_READ_SIG = 4'b0001,
    OP_READ_QUERY = 4'b0010,
    OP_READ_STATUS = 4'b0011,
    OP_CLEAR = 4'b0100,
    OP_ERASE = 4'b0101,
    OP_PROGRAM = 4'b0110,
    OP_BUF_PROGRAM = 4'b0111,
    OP_SUSPEND = 4'b1000,
    OP_RESUME = 4'b1001,
    OP_PROTECT = 4'b1010
  } fcs_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CLEAR = 4'b0001,
    S_PRE_RA = 4'b0010,
    S_CMD = 4'b0011,
    S_ARG = 4'b0100,
    S_COUNT = 4'b0101,
    S_LOAD = 4'b0110,
    S_CONFIRM = 4'b0111,
    S_POLL = 4'b1000,
    S_SUSP = 4'b1001,
    S_READ = 4'b1010
  } fcs_state_t;

  typedef enum logic [2:0] {
    B_RST = 3'b000,
    B_RPH = 3'b001,
    B_IDLE = 3'b010,
    B_SETUP = 3'b011,
    B_STROBE = 3'b100,
    B_HOLD = 3'b101
  } fcs_bstate_t;

endpackage
